/* design/eeprom_byte_access_ctrl.sv */
// cpu io-register front end for the 512-byte data store with guarded self-timed write
`include "nvm_access_regs.svh"

module eeprom_byte_access_ctrl #(
    parameter int DEPTH = 512,
    parameter int WRITE_CYC = `NVM_WRITE_OSC_CYC,
    parameter int ERASE_CYC = `NVM_WRITE_OSC_CYC / 2
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic osc_tick_i,
    input wire logic [5:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic cpu_stall_o,
    output logic ready_irq_o
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] mem [DEPTH];
    logic [8:0] nvm_address_reg;
    logic [7:0] nvm_data_reg;
    nvm_access_pkg::prog_mode_t mode_reg;
    logic ready_irq_enable_reg;
    logic master_write_enable_reg;
    logic [2:0] master_cnt_reg;
    nvm_access_pkg::write_state_t state_reg;
    logic [15:0] timer_reg;
    logic [7:0] write_byte_reg;
    logic [8:0] write_addr_reg;
    logic osc_meta_reg;
    logic osc_sync_reg;
    logic osc_prev_reg;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire sel_ctl = io_addr_i == `NVM_CONTROL_OFS;
    wire sel_lo = io_addr_i == `NVM_ADDRESS_LOW_OFS;
    wire sel_hi = io_addr_i == `NVM_ADDRESS_HIGH_OFS;
    wire sel_data = io_addr_i == `NVM_DATA_OFS;
    wire busy = state_reg == nvm_access_pkg::ST_BUSY;
    wire ctl_wr = io_wr_i && sel_ctl;
    wire read_trig = ctl_wr && io_wdata_i[`NVM_READ_STROBE_BIT] && !busy;
    wire prog_trig = ctl_wr && io_wdata_i[`NVM_PROGRAM_STROBE_BIT] && master_write_enable_reg && !busy;
    wire master_set = ctl_wr && io_wdata_i[`NVM_MASTER_ENABLE_BIT];
    wire addr_wr_ok = io_wr_i && !busy;
    wire osc_edge = osc_sync_reg && !osc_prev_reg;
    wire [8:0] rd_index = nvm_address_reg;
    nvm_access_pkg::prog_mode_t new_mode;
    assign new_mode = nvm_access_pkg::prog_mode_t'(io_wdata_i[`NVM_MODE_HI_BIT:`NVM_MODE_LO_BIT]);
    // reserved mode runs as erase plus write, so it needs the full write time
    wire split_mode = (mode_reg == nvm_access_pkg::MODE_ERASE_ONLY) ||
                      (mode_reg == nvm_access_pkg::MODE_WRITE_ONLY);
    wire [15:0] write_len = split_mode ? 16'(ERASE_CYC) : 16'(WRITE_CYC);

    wire [7:0] ctl_view = {2'h0, mode_reg, ready_irq_enable_reg, master_write_enable_reg, busy, 1'b0};
    assign io_rdata_o = !io_rd_i ? 8'h00 :
                        sel_ctl ? ctl_view :
                        sel_lo ? nvm_address_reg[7:0] :
                        sel_hi ? {7'h00, nvm_address_reg[8]} :
                        sel_data ? nvm_data_reg : 8'h00;
    assign ready_irq_o = ready_irq_enable_reg && !busy;

    // ----------------------------------------------------------------
    // stall
    // ----------------------------------------------------------------
    wire stall_load = read_trig || prog_trig;
    wire [2:0] stall_len = read_trig ? 3'(`NVM_READ_STALL_CYC) : 3'(`NVM_WRITE_STALL_CYC);
    nvm_stall_counter #(.WIDTH(3)) u_stall (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .load_i(stall_load),
        .count_i(stall_len),
        .stall_o(cpu_stall_o)
    );

    // ----------------------------------------------------------------
    // oscillator tick synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_meta_reg <= osc_tick_i;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    // ----------------------------------------------------------------
    // address and data registers, no reset
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (addr_wr_ok && sel_lo) begin
            nvm_address_reg[7:0] <= io_wdata_i;
        end
        if (addr_wr_ok && sel_hi) begin
            nvm_address_reg[8] <= io_wdata_i[0];
        end
        if (read_trig) begin
            nvm_data_reg <= mem[rd_index];
        end else if (io_wr_i && sel_data) begin
            nvm_data_reg <= io_wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // array: updates the captured address at the end of the timed write (erase, and-write or plain write by mode)
    // ----------------------------------------------------------------
    wire write_done = busy && osc_edge && (timer_reg == 16'h0001);
    always_ff @(posedge sys_clk_i) begin
        if (write_done) begin
            case (mode_reg)
                nvm_access_pkg::MODE_ERASE_ONLY: mem[write_addr_reg] <= 8'hFF;
                nvm_access_pkg::MODE_WRITE_ONLY: mem[write_addr_reg] <= mem[write_addr_reg] & write_byte_reg;
                default: mem[write_addr_reg] <= write_byte_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // control register and write sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg <= nvm_access_pkg::MODE_ERASE_WRITE;
            ready_irq_enable_reg <= 1'b0;
            master_write_enable_reg <= 1'b0;
            master_cnt_reg <= 3'h0;
            state_reg <= nvm_access_pkg::ST_IDLE;
            timer_reg <= 16'h0000;
            write_byte_reg <= 8'h00;
            write_addr_reg <= 9'h000;
        end else begin
            if (ctl_wr) begin
                ready_irq_enable_reg <= io_wdata_i[`NVM_IRQ_ENABLE_BIT];
                if (!busy && !prog_trig) begin
                    mode_reg <= new_mode;
                end
            end
            if (master_set) begin
                master_write_enable_reg <= 1'b1;
                master_cnt_reg <= 3'(`NVM_MASTER_WINDOW_CYC);
            end else if (master_cnt_reg != 3'h0) begin
                master_cnt_reg <= master_cnt_reg - 3'h1;
                if (master_cnt_reg == 3'h1) begin
                    master_write_enable_reg <= 1'b0;
                end
            end
            case (state_reg)
                nvm_access_pkg::ST_IDLE: begin
                    if (prog_trig) begin
                        state_reg <= nvm_access_pkg::ST_BUSY;
                        timer_reg <= write_len;
                        write_byte_reg <= nvm_data_reg;
                        write_addr_reg <= nvm_address_reg;
                        master_write_enable_reg <= 1'b0;
                        master_cnt_reg <= 3'h0;
                    end
                end
                nvm_access_pkg::ST_BUSY: begin
                    if (write_done) begin
                        state_reg <= nvm_access_pkg::ST_IDLE;
                    end else if (osc_edge) begin
                        timer_reg <= timer_reg - 16'h0001;
                    end
                end
                default: state_reg <= nvm_access_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_READ_STALL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        read_trig |=> cpu_stall_o [*4] ##1 !cpu_stall_o) else $error("read stall not four cycles");
    AST_WRITE_STALL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        prog_trig |=> cpu_stall_o [*2] ##1 !cpu_stall_o) else $error("write stall not two cycles");
    AST_MASTER_TIMEOUT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (master_set && !prog_trig && !busy) ##1 !ctl_wr [*4] |=> !master_write_enable_reg)
        else $error("master enable did not time out");
    AST_GUARD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ($rose(busy)) |-> $past(master_write_enable_reg)) else $error("write without master enable");
    AST_BUSY_FLAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        io_rd_i && sel_ctl |-> io_rdata_o[`NVM_PROGRAM_STROBE_BIT] == busy) else $error("strobe not shown");
    AST_ADDR_FROZEN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        busy && $past(busy) |-> $stable(nvm_address_reg)) else $error("address changed during write");
    AST_IRQ_LEVEL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        write_done && ready_irq_enable_reg && !ctl_wr |=> ready_irq_o) else $error("ready irq not raised after write");
    AST_RESERVED_ZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        io_rd_i && (sel_ctl || sel_hi) |-> io_rdata_o[7:6] == 2'h0) else $error("reserved bits not zero");
    AST_MODE_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        busy |=> $stable(mode_reg)) else $error("mode changed while busy");
    COV_READ: cover property (@(posedge sys_clk_i) disable iff (rst_i) read_trig);
    COV_WRITE: cover property (@(posedge sys_clk_i) disable iff (rst_i) write_done);
    COV_LATE_STROBE: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        master_set ##5 (ctl_wr && io_wdata_i[`NVM_PROGRAM_STROBE_BIT]));
endmodule // eeprom_byte_access_ctrl

/* design/nvm_access_regs.svh */
// register offsets, field positions and timing counts of the data-store access block
`ifndef NVM_ACCESS_REGS_SVH
`define NVM_ACCESS_REGS_SVH
`define NVM_CONTROL_OFS 6'h1F
`define NVM_ADDRESS_LOW_OFS 6'h21
`define NVM_ADDRESS_HIGH_OFS 6'h22
`define NVM_DATA_OFS 6'h20
`define NVM_READ_STROBE_BIT 0
`define NVM_PROGRAM_STROBE_BIT 1
`define NVM_MASTER_ENABLE_BIT 2
`define NVM_IRQ_ENABLE_BIT 3
`define NVM_MODE_LO_BIT 4
`define NVM_MODE_HI_BIT 5
`define NVM_MODE_RESET 2'h0
`define NVM_READ_STALL_CYC 4
`define NVM_WRITE_STALL_CYC 2
`define NVM_MASTER_WINDOW_CYC 4
`define NVM_WRITE_OSC_CYC 26368
`endif

/* design/nvm_access_pkg.sv */
// types shared by the data-store access block
package nvm_access_pkg;
    typedef enum logic [1:0] {
        MODE_ERASE_WRITE,
        MODE_ERASE_ONLY,
        MODE_WRITE_ONLY,
        MODE_RESERVED
    } prog_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY
    } write_state_t;
endpackage

/* design/nvm_stall_counter.sv */
// down counter that holds the cpu stall line for a loaded number of cycles
module nvm_stall_counter #(
    parameter int WIDTH = 3
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] count_i,
    output logic stall_o
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    assign count_next = load_i ? count_i : ((count_reg != '0) ? count_reg - 1'b1 : count_reg);
    assign stall_o = (count_reg != '0);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule // nvm_stall_counter

/* test/cpu_io_model.sv */
// cpu-side io master model for the data-store access block
module cpu_io_model (
    input wire logic sys_clk_i,
    input wire logic cpu_stall_i,
    input wire logic [7:0] io_rdata_i,
    output logic [5:0] io_addr_o,
    output logic io_wr_o,
    output logic io_rd_o,
    output logic [7:0] io_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // io access tasks
    // ----------------------------------------
    initial begin
        io_addr_o = 6'h3F;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'h00;
    end
    // a halted cpu issues nothing, so wait out the stall first
    task automatic wait_go();
        @(negedge sys_clk_i);
        while (cpu_stall_i === 1'b1) @(negedge sys_clk_i);
    endtask
    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        wait_go();
        io_addr_o = a;
        io_wdata_o = d;
        io_wr_o = 1'b1;
        @(negedge sys_clk_i);
        io_wr_o = 1'b0;
        // released lines must not keep looking valid
        io_addr_o = ~a;
        io_wdata_o = ~d;
    endtask
    task automatic io_read(input logic [5:0] a, output logic [7:0] d);
        wait_go();
        io_addr_o = a;
        io_rd_o = 1'b1;
        @(posedge sys_clk_i);
        d = io_rdata_i;
        @(negedge sys_clk_i);
        io_rd_o = 1'b0;
        io_addr_o = ~a;
    endtask
endmodule // cpu_io_model

/* test/tb_top.sv */
// self-checking bench for the data-store access block
`include "nvm_access_regs.svh"
`define CHECK_EQ(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk;
    logic rst;
    logic osc_tick;
    logic [5:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic cpu_stall;
    logic ready_irq;
    logic [7:0] v;
    int fail_count = 0;
    int check_count = 0;
    // ----------------------------------------
    // clocks, design and cpu model
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        osc_tick = 1'b0;
        forever begin
            repeat (2) @(negedge sys_clk);
            osc_tick = ~osc_tick;
        end
    end
    // short write times keep each program cycle to a few dozen clocks
    eeprom_byte_access_ctrl #(.DEPTH(512), .WRITE_CYC(16), .ERASE_CYC(8)) i_dut (.sys_clk_i(sys_clk),
        .rst_i(rst), .osc_tick_i(osc_tick), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
        .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .cpu_stall_o(cpu_stall), .ready_irq_o(ready_irq));
    cpu_io_model i_cpu (.sys_clk_i(sys_clk), .cpu_stall_i(cpu_stall), .io_rdata_i(io_rdata),
        .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd), .io_wdata_o(io_wdata));
    // ----------------------------------------
    // helpers and scenarios
    // ----------------------------------------
    task automatic stall_len(output int n);
        n = int'(cpu_stall === 1'b1);
        repeat (7) begin
            @(negedge sys_clk);
            n += int'(cpu_stall === 1'b1);
        end
    endtask
    task automatic set_addr(input logic [8:0] a);
        i_cpu.io_write(`NVM_ADDRESS_HIGH_OFS, {7'h7F, a[8]});
        i_cpu.io_write(`NVM_ADDRESS_LOW_OFS, a[7:0]);
    endtask
    task automatic wait_idle();
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 0; i < 100 && c[1] !== 1'b0; i++) i_cpu.io_read(`NVM_CONTROL_OFS, c);
        `CHECK_EQ(c[1], 1'b0)
    endtask
    task automatic nvm_start(input logic [8:0] a, input logic [7:0] d, input logic [2:0] mi);
        int n;
        logic [7:0] c;
        set_addr(a);
        i_cpu.io_write(`NVM_DATA_OFS, d);
        i_cpu.io_write(`NVM_CONTROL_OFS, {2'h0, mi, 3'h4});
        i_cpu.io_write(`NVM_CONTROL_OFS, {2'h0, mi, 3'h2});
        stall_len(n);
        `CHECK_EQ(n, 2)
        i_cpu.io_read(`NVM_CONTROL_OFS, c);
        `CHECK_EQ(c[1], 1'b1)
        `CHECK_EQ(ready_irq, 1'b0)
    endtask
    task automatic nvm_read(input logic [8:0] a, input logic [7:0] e);
        int n;
        logic [7:0] d;
        set_addr(a);
        i_cpu.io_write(`NVM_CONTROL_OFS, 8'h01);
        stall_len(n);
        `CHECK_EQ(n, 4)
        i_cpu.io_read(`NVM_DATA_OFS, d);
        `CHECK_EQ(d, e)
    endtask
    task automatic t_regs();
        i_cpu.io_read(`NVM_CONTROL_OFS, v);
        `CHECK_EQ(v, 8'h00)
        i_cpu.io_write(`NVM_ADDRESS_HIGH_OFS, 8'hFF);
        i_cpu.io_read(`NVM_ADDRESS_HIGH_OFS, v);
        `CHECK_EQ(v, 8'h01)
        i_cpu.io_write(`NVM_CONTROL_OFS, 8'hC8);
        i_cpu.io_read(`NVM_CONTROL_OFS, v);
        `CHECK_EQ(v, 8'h08)
        `CHECK_EQ(ready_irq, 1'b1)
        i_cpu.io_write(`NVM_CONTROL_OFS, 8'h02);
        i_cpu.io_read(`NVM_CONTROL_OFS, v);
        `CHECK_EQ(v, 8'h00)
        i_cpu.io_write(`NVM_CONTROL_OFS, 8'h06);
        i_cpu.io_read(`NVM_CONTROL_OFS, v);
        `CHECK_EQ(v, 8'h04)
        repeat (6) @(negedge sys_clk);
        i_cpu.io_read(`NVM_CONTROL_OFS, v);
        `CHECK_EQ(v, 8'h00)
    endtask
    task automatic t_write_read();
        nvm_start(9'h1A5, 8'h3C, {nvm_access_pkg::MODE_ERASE_WRITE, 1'b0});
        wait_idle();
        nvm_read(9'h1A5, 8'h3C);
        // reserved mode behaves as erase plus write
        nvm_start(9'h0F0, 8'hC3, {nvm_access_pkg::MODE_RESERVED, 1'b0});
        wait_idle();
        nvm_read(9'h0F0, 8'hC3);
    endtask
    task automatic t_busy();
        nvm_start(9'h0A5, 8'h11, {nvm_access_pkg::MODE_ERASE_ONLY, 1'b1});
        i_cpu.io_write(`NVM_ADDRESS_LOW_OFS, 8'h00);
        i_cpu.io_write(`NVM_CONTROL_OFS, 8'h29);
        wait_idle();
        `CHECK_EQ(ready_irq, 1'b1)
        i_cpu.io_read(`NVM_CONTROL_OFS, v);
        `CHECK_EQ(v, 8'h18)
        i_cpu.io_read(`NVM_ADDRESS_LOW_OFS, v);
        `CHECK_EQ(v, 8'hA5)
        nvm_read(9'h0A5, 8'hFF);
        nvm_read(9'h1A5, 8'h3C);
    endtask
    task automatic t_write_only();
        nvm_start(9'h0A5, 8'h5A, {nvm_access_pkg::MODE_WRITE_ONLY, 1'b0});
        // a new write may only start once the strobe reads zero again
        wait_idle();
        nvm_start(9'h0A5, 8'h0F, {nvm_access_pkg::MODE_WRITE_ONLY, 1'b0});
        wait_idle();
        `CHECK_EQ(ready_irq, 1'b0)
        nvm_read(9'h0A5, 8'h0A);
    endtask
    task automatic results();
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        t_regs();
        t_write_read();
        t_busy();
        t_write_only();
        results();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        results();
    end
endmodule // tb_top
